// ==== src/tfm_channel.v ====
/*
 One time and frequency measurement channel: picks a measured and a
 qualifying input from a vector of sensor pins, measures times on a 20 ns
 timebase and derives frequency, duty cycle and RPM with a serial divider.
 Assumes asynchronous sensor pins and a register master on the same clock.
*/
`timescale 1ns/1ps
`include "tfm_defines.vh"
module tfm_channel #(
   parameter NCH  = 4,                  // Number of sensor pins.
   parameter IDXW = 2                   // Width of a channel index.
) (
   // Clock, reset and clock enable.
   input  wire            mclk_i,
   input  wire            rstn_i,
   input  wire            ce_i,
   // Sensor pins.
   input  wire [NCH-1:0]  sig_i,
   // Register port.
   input  wire [7:0]      addr_i,
   input  wire [31:0]     wdata_i,
   input  wire            wr_i,
   input  wire            rd_i,
   output reg  [31:0]     rdata_o,
   // One-cycle pulse when a new coherent result set is published.
   output reg             result_valid_o
);
   // Cycles per timebase tick, rounded up.
   localparam integer TICK_DIV  = (`TFM_TICK_NS + `TFM_CLK_NS - 1) / `TFM_CLK_NS;
   localparam [3:0]   TICK_LAST = TICK_DIV[3:0] - 4'h1;
   // Divider states.
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_LOAD = 2'h1;
   localparam [1:0] ST_RUN  = 2'h2;
   localparam [1:0] ST_PUB  = 2'h3;

   // Adds two 32-bit times, wrapping like the hardware counter.
   function [31:0] tsum;
      input [31:0] a;
      input [31:0] b;
      begin
         tsum = a + b;
      end
   endfunction

   reg [`TFM_CTRL_BITS-1:0] ctrl_q;     // Control register.
   reg [15:0]      chsel_q;             // Measured and qualifier index.
   reg [15:0]      ppc_q;               // Periods per cycle.
   reg [NCH-1:0]   s1_q, s2_q, s3_q;    // Pin synchroniser stages.
   reg [NCH-1:0]   lvl_q;               // Debounced pin levels.
   reg             m_p_q, q_p_q;        // Previous measured and qualifier level.
   reg             gate_p_q;            // Previous gate state.
   reg [3:0]       tick_cnt_q;          // Timebase prescaler.
   reg [31:0]      cur_act_q, cur_inact_q;  // Running period.
   reg [31:0]      lp_act_q, lp_inact_q;    // Last period.
   reg [31:0]      cyc_act_q, cyc_inact_q;  // Running cycle.
   reg [31:0]      lc_act_q, lc_inact_q;    // Last cycle.
   reg [15:0]      per_cnt_q;           // Periods seen in this cycle.
   reg [31:0]      bs_act_q, bs_inact_q;    // Since last sample.
   reg [31:0]      acc_act_q, acc_inact_q;  // Accumulated timer.
   reg [31:0]      hold_act_q, hold_inact_q; // Accumulated at window close.
   reg [31:0]      sn_act_q, sn_inact_q, sn_per_q; // Sample snapshot.
   reg [31:0]      sn_dact_q, sn_dinact_q;  // Duty inputs.
   reg [31:0]      sn_cyc_q;            // Cycle duration for RPM.
   reg             sn_neg_q;            // Sign at the sample.
   reg [31:0]      r_act_q, r_inact_q, r_per_q, r_freq_q, r_duty_q, r_rpm_q;
   reg [31:0]      fmag_q, duty_q;      // Divider results awaiting publication.
   reg [1:0]       st_q;                // Divider state.
   reg [1:0]       op_q;                // 0 frequency, 1 duty, 2 RPM.
   reg [5:0]       step_q;              // Divider step count.
   reg [39:0]      quo_q;               // Dividend shifting into quotient.
   reg [32:0]      rem_q;               // Partial remainder.
   reg [31:0]      den_q;               // Divisor.

   // Decoded configuration.
   wire            en     = ctrl_q[`TFM_CTRL_EN];
   wire [1:0]      win    = ctrl_q[`TFM_CTRL_WIN];
   wire [1:0]      rmode  = ctrl_q[`TFM_CTRL_RMODE];
   wire [2:0]      qmode  = ctrl_q[`TFM_CTRL_QMODE];
   wire [IDXW-1:0] midx   = chsel_q[IDXW-1:0];
   wire [IDXW-1:0] qidx   = chsel_q[IDXW+7:8];
   // Selected levels and edges.
   wire            m      = lvl_q[midx];
   wire            q      = lvl_q[qidx];
   wire            m_rise = m & ~m_p_q;
   wire            m_fall = ~m & m_p_q;
   wire            bound  = ctrl_q[`TFM_CTRL_PFALL] ? m_fall : m_rise;
   wire            q_edge = ctrl_q[`TFM_CTRL_QFALL] ? (~q & q_p_q) : (q & ~q_p_q);
   wire            tick   = (tick_cnt_q == TICK_LAST);
   // Gating applies only in the accumulate window.
   wire            gated  = (win == 2'h3) &&
                            (qmode == 3'h1 || qmode == 3'h2);
   wire            gate   = !gated ? 1'b1 :
                            (qmode == 3'h1) ? q : ~q;
   wire [31:0]     inc_a  = {31'h0, tick & m};
   wire [31:0]     inc_i  = {31'h0, tick & ~m};
   wire [31:0]     inc_ga = {31'h0, tick & m & gate};
   wire [31:0]     inc_gi = {31'h0, tick & ~m & gate};
   wire [31:0]     ca_n   = tsum(cur_act_q, inc_a);
   wire [31:0]     ci_n   = tsum(cur_inact_q, inc_i);
   wire [31:0]     cyc_a  = tsum(cyc_act_q, ca_n);
   wire [31:0]     cyc_i  = tsum(cyc_inact_q, ci_n);
   wire            cyc_end = (per_cnt_q + 16'h0001) >= ppc_q;
   wire            sample = wr_i && (addr_i == `TFM_REG_SAMPLE) && (st_q == ST_IDLE);
   // Timer reset request, never taken in gated modes.
   wire            acc_clr = !gated &&
                             ((rmode == 2'h0 && sample) ||
                              (rmode == 2'h1 && q_edge));
   // Restoring divider step.
   wire [32:0]     rem_sh = {rem_q[31:0], quo_q[39]};
   wire            fits   = rem_sh >= {1'b0, den_q};
   // 100 * active time for the duty quotient.
   wire [39:0]     act100 = {2'h0, sn_dact_q, 6'h0} + {3'h0, sn_dact_q, 5'h0} +
                            {6'h0, sn_dact_q, 2'h0};
   wire [31:0]     fsigned = sn_neg_q ? (32'h0 - fmag_q) : fmag_q;

   // Register writes; the sample strobe has no storage of its own.
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         ctrl_q  <= `TFM_CTRL_RST;
         chsel_q <= `TFM_CHSEL_RST;
         ppc_q   <= `TFM_PPC_RST;
      end else if (ce_i && wr_i) begin
         case (addr_i)
            `TFM_REG_CTRL:  ctrl_q  <= wdata_i[`TFM_CTRL_BITS-1:0];
            `TFM_REG_CHSEL: chsel_q <= wdata_i[15:0];
            `TFM_REG_PPC:   ppc_q   <= wdata_i[15:0];
            default: begin
            end
         endcase
      end
   end

   // Three-stage pin synchroniser; a level counts once stages two and three
   // agree, which also drops single-cycle glitches.
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         s1_q  <= {NCH{1'b0}};
         s2_q  <= {NCH{1'b0}};
         s3_q  <= {NCH{1'b0}};
         lvl_q <= {NCH{1'b0}};
      end else if (ce_i) begin
         s1_q  <= sig_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
      end
   end

   // Edge history and the 20 ns prescaler.
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         m_p_q      <= 1'b0;
         q_p_q      <= 1'b0;
         gate_p_q   <= 1'b0;
         tick_cnt_q <= 4'h0;
      end else if (ce_i) begin
         m_p_q      <= m;
         q_p_q      <= q;
         gate_p_q   <= gate;
         tick_cnt_q <= (tick || !en) ? 4'h0 : tick_cnt_q + 4'h1;
      end
   end

   // Period and cycle measurement; all three values run whatever is
   // reported.
   always @(posedge mclk_i) begin
      if (!rstn_i || (ce_i && !en)) begin
         cur_act_q   <= 32'h0;
         cur_inact_q <= 32'h0;
         lp_act_q    <= 32'h0;
         lp_inact_q  <= 32'h0;
         cyc_act_q   <= 32'h0;
         cyc_inact_q <= 32'h0;
         lc_act_q    <= 32'h0;
         lc_inact_q  <= 32'h0;
         per_cnt_q   <= 16'h0;
      end else if (ce_i) begin
         if (bound) begin
            // Close the period; the boundary tick belongs to the old one.
            lp_act_q    <= ca_n;
            lp_inact_q  <= ci_n;
            cur_act_q   <= 32'h0;
            cur_inact_q <= 32'h0;
            if (cyc_end) begin
               lc_act_q    <= cyc_a;
               lc_inact_q  <= cyc_i;
               cyc_act_q   <= 32'h0;
               cyc_inact_q <= 32'h0;
               per_cnt_q   <= 16'h0;
            end else begin
               cyc_act_q   <= cyc_a;
               cyc_inact_q <= cyc_i;
               per_cnt_q   <= per_cnt_q + 16'h1;
            end
         end else begin
            cur_act_q   <= ca_n;
            cur_inact_q <= ci_n;
         end
      end
   end

   // Between-sample and accumulated timers; the accumulator wraps at 2^32.
   always @(posedge mclk_i) begin
      if (!rstn_i || (ce_i && !en)) begin
         bs_act_q     <= 32'h0;
         bs_inact_q   <= 32'h0;
         acc_act_q    <= 32'h0;
         acc_inact_q  <= 32'h0;
         hold_act_q   <= 32'h0;
         hold_inact_q <= 32'h0;
      end else if (ce_i) begin
         bs_act_q   <= sample ? 32'h0 : tsum(bs_act_q, inc_a);
         bs_inact_q <= sample ? 32'h0 : tsum(bs_inact_q, inc_i);
         if (acc_clr) begin
            acc_act_q   <= 32'h0;
            acc_inact_q <= 32'h0;
         end else begin
            // No tick is dropped between samples, only on explicit reset.
            acc_act_q   <= tsum(acc_act_q, inc_ga);
            acc_inact_q <= tsum(acc_inact_q, inc_gi);
         end
         // A gated value is only trusted once the window has closed, since
         // measured and qualifier edges are unrelated in time.
         if (gate_p_q && !gate) begin
            hold_act_q   <= acc_act_q;
            hold_inact_q <= acc_inact_q;
         end
      end
   end

   // Snapshot on the sample strobe, then a serial divider for the three
   // quotients; samples arriving while it runs are ignored.
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         st_q <= ST_IDLE;
         op_q <= 2'h0;
         step_q <= 6'h0;
         quo_q <= 40'h0;
         rem_q <= 33'h0;
         den_q <= 32'h0;
         sn_act_q <= 32'h0;
         sn_inact_q <= 32'h0;
         sn_per_q <= 32'h0;
         sn_dact_q <= 32'h0;
         sn_dinact_q <= 32'h0;
         sn_cyc_q <= 32'h0;
         sn_neg_q <= 1'b0;
         fmag_q <= 32'h0;
         duty_q <= 32'h0;
         r_act_q <= 32'h0;
         r_inact_q <= 32'h0;
         r_per_q <= 32'h0;
         r_freq_q <= 32'h0;
         r_duty_q <= 32'h0;
         r_rpm_q <= 32'h0;
         result_valid_o <= 1'b0;
      end else if (ce_i) begin
         result_valid_o <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (sample) begin
                  case (win)
                     2'h0: begin
                        sn_act_q   <= lp_act_q;
                        sn_inact_q <= lp_inact_q;
                     end
                     2'h1: begin
                        sn_act_q   <= lc_act_q;
                        sn_inact_q <= lc_inact_q;
                     end
                     2'h2: begin
                        sn_act_q   <= bs_act_q;
                        sn_inact_q <= bs_inact_q;
                     end
                     default: begin
                        sn_act_q   <= gated ? hold_act_q : acc_act_q;
                        sn_inact_q <= gated ? hold_inact_q : acc_inact_q;
                     end
                  endcase
                  // Duration for frequency and duty: last period or cycle.
                  if (ctrl_q[`TFM_CTRL_FCYC]) begin
                     sn_per_q    <= tsum(lc_act_q, lc_inact_q);
                     sn_dact_q   <= lc_act_q;
                     sn_dinact_q <= lc_inact_q;
                  end else begin
                     sn_per_q    <= tsum(lp_act_q, lp_inact_q);
                     sn_dact_q   <= lp_act_q;
                     sn_dinact_q <= lp_inact_q;
                  end
                  sn_cyc_q <= tsum(lc_act_q, lc_inact_q);
                  case (qmode)
                     3'h3: sn_neg_q <= ~q;
                     3'h4: sn_neg_q <= q;
                     3'h5: sn_neg_q <= (m != q);
                     3'h6: sn_neg_q <= (m == q);
                     default: sn_neg_q <= 1'b0;
                  endcase
                  op_q <= 2'h0;
                  st_q <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               rem_q  <= 33'h0;
               step_q <= 6'h0;
               case (op_q)
                  2'h0: begin
                     quo_q <= `TFM_FREQ_NUM;
                     den_q <= sn_per_q;
                  end
                  2'h1: begin
                     quo_q <= act100;
                     den_q <= tsum(sn_dact_q, sn_dinact_q);
                  end
                  default: begin
                     quo_q <= `TFM_RPM_NUM;
                     den_q <= sn_cyc_q;
                  end
               endcase
               st_q <= ST_RUN;
            end
            ST_RUN: begin
               if (step_q == `TFM_DIV_STEPS) begin
                  // A zero duration yields zero rather than a bogus quotient.
                  case (op_q)
                     2'h0: fmag_q <= (den_q == 32'h0) ? 32'h0 :
                                     (quo_q[39:31] != 9'h0) ? `TFM_FREQ_MAX :
                                     quo_q[31:0];
                     2'h1: duty_q <= (den_q == 32'h0) ? 32'h0 : quo_q[31:0];
                     default: begin
                     end
                  endcase
                  if (op_q == 2'h2) begin
                     r_rpm_q <= (den_q == 32'h0) ? 32'h0 : quo_q[31:0];
                     st_q    <= ST_PUB;
                  end else begin
                     op_q <= op_q + 2'h1;
                     st_q <= ST_LOAD;
                  end
               end else begin
                  rem_q  <= fits ? (rem_sh - {1'b0, den_q}) : rem_sh;
                  quo_q  <= {quo_q[38:0], fits};
                  step_q <= step_q + 6'h1;
               end
            end
            default: begin
               // Publish the set in one cycle for a coherent read; r_rpm_q is written one cycle earlier, at the end of the RPM division.
               r_act_q        <= sn_act_q;
               r_inact_q      <= sn_inact_q;
               r_per_q        <= sn_per_q;
               r_freq_q       <= fsigned;
               r_duty_q       <= duty_q;
               result_valid_o <= 1'b1;
               st_q           <= ST_IDLE;
            end
         endcase
      end
   end

   // Read data, registered one cycle after the strobe; unmapped reads zero.
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         rdata_o <= 32'h0;
      end else if (ce_i) begin
         if (rd_i) begin
            case (addr_i)
               `TFM_REG_CTRL:   rdata_o <= {21'h0, ctrl_q};
               `TFM_REG_CHSEL:  rdata_o <= {16'h0, chsel_q};
               `TFM_REG_PPC:    rdata_o <= {16'h0, ppc_q};
               `TFM_REG_ACT:    rdata_o <= r_act_q;
               `TFM_REG_INACT:  rdata_o <= r_inact_q;
               `TFM_REG_PERIOD: rdata_o <= r_per_q;
               `TFM_REG_FREQ:   rdata_o <= r_freq_q;
               `TFM_REG_DUTY:   rdata_o <= r_duty_q;
               `TFM_REG_RPM:    rdata_o <= r_rpm_q;
               `TFM_REG_STATUS: rdata_o <= {28'h0, gate, q, m, (st_q != ST_IDLE)};
               default:         rdata_o <= 32'h0;
            endcase
         end else begin
            rdata_o <= 32'h0;
         end
      end
   end
endmodule

// ==== src/tfm_defines.vh ====
/*
 Register offsets, field positions, reset values and timing counts shared by
 the time and frequency measurement channel. Assumes a 100 MHz system clock
 and a register master on a plain strobe port.
*/
// Functional notes
// - Always capture active, inactive and period time.
// - Channel configurable standalone or with qualifier.
// - Four windows: period, cycle, between samples, accumulate.
// - Timer reset: per sample, qualifier edge, free.
// - Free timer is 32 bits, wraps to zero.
// - Accumulated active time has no gaps.
// - Period equals active plus inactive time.
// - Period starts on selectable edge.
// - Gating only with accumulate window selected.
// - Gate counting on qualifier active or inactive.
// - Gated modes never reset the timer.
// - Gated result updates when qualifier window closes.
// - Frequency is reciprocal of measured duration.
// - Frequency uses last period or last cycle.
// - Frequency and duty use selected duration.
// - RPM from cycle frequency.
// - Level sign modes follow qualifier state.
// - Compare sign modes follow state equality.
// - Duty is active over period, in percent.
// - Frequency integer in 0.02 Hz steps.
`ifndef TFM_DEFINES_VH
`define TFM_DEFINES_VH
// Register byte offsets.
`define TFM_REG_CTRL     8'h00
`define TFM_REG_CHSEL    8'h04
`define TFM_REG_PPC      8'h08
`define TFM_REG_SAMPLE   8'h0C
`define TFM_REG_ACT      8'h10
`define TFM_REG_INACT    8'h14
`define TFM_REG_PERIOD   8'h18
`define TFM_REG_FREQ     8'h1C
`define TFM_REG_DUTY     8'h20
`define TFM_REG_RPM      8'h24
`define TFM_REG_STATUS   8'h28
// Control field positions.
`define TFM_CTRL_EN      0
`define TFM_CTRL_WIN     2:1
`define TFM_CTRL_RMODE   4:3
`define TFM_CTRL_PFALL   5
`define TFM_CTRL_QFALL   6
`define TFM_CTRL_QMODE   9:7
`define TFM_CTRL_FCYC    10
`define TFM_CTRL_BITS    11
// Reset values.
`define TFM_CTRL_RST     11'h000
`define TFM_CHSEL_RST    16'h0100
`define TFM_PPC_RST      16'h0001
// Timing: 20 ns timebase on a 10 ns clock.
`define TFM_TICK_NS      20
`define TFM_CLK_NS       10
// 2.5e9 = 1 / (20 ns * 0.02 Hz); 3.0e9 = 60 / 20 ns.
`define TFM_FREQ_NUM     40'h00_9502_F900
`define TFM_RPM_NUM      40'h00_B2D0_5E00
`define TFM_FREQ_MAX     32'h7FFF_FFFF
`define TFM_DIV_STEPS    6'h28
`endif

// ==== verif/testbench.sv ====
/*
 Self-checking bench for the measurement channel with a sensor model.
 Assumes a 100 MHz clock; ce_i is held high throughout.
*/
`timescale 1ns/1ps
`include "tfm_defines.vh"
module testbench;
   reg         mclk_i = 1'b0;           // System clock.
   reg         rstn_i = 1'b0;           // Synchronous reset, active low.
   reg  [7:0]  addr_i = 8'h00;          // Register address.
   reg  [31:0] wdata_i = 32'h0;         // Write data.
   reg         wr_i = 1'b0;             // Write strobe.
   reg         rd_i = 1'b0;             // Read strobe.
   reg  [15:0] hi_q = 16'h0028;         // Sensor high length.
   reg  [15:0] lo_q = 16'h0028;         // Sensor low length.
   reg         qual_q = 1'b0;           // Qualifier level.
   wire [3:0]  sig_w;                   // Sensor pins.
   wire [31:0] rdata_o;                 // Read data.
   wire        result_valid_o;          // Result strobe.
   reg  [31:0] rv;                      // Last read value.
   reg  [31:0] a0;                      // Earlier value for comparison.
   integer     n_errors = 0;
   integer     cmp_count = 0;
   integer     i, h, l, p, m, win, fc, qm, q, neg, t0, ts;
   // Clock of 10 ns period.
   always #5 mclk_i = ~mclk_i;
   tfm_sensor u_sens (.mclk_i(mclk_i), .hi_len_i(hi_q), .lo_len_i(lo_q), .qual_i(qual_q),
      .sig_o(sig_w));
   tfm_channel #(.NCH(4), .IDXW(2)) DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1),
      .sig_i(sig_w), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .result_valid_o(result_valid_o));
   // Expected signed frequency from a duration in ticks.
   function [31:0] freq_exp(input [31:0] t, input n);
      reg [39:0] f;
      f = `TFM_FREQ_NUM / t;
      if (f > `TFM_FREQ_MAX) f = `TFM_FREQ_MAX;
      freq_exp = n ? -f[31:0] : f[31:0];
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // A wait that runs out ends the run.
   task give_up;
      n_errors = n_errors + 1;
      $display("mismatch at %0t: wait ran out", $time);
      print_verdict;
   endtask
   task wr_reg(input [7:0] a, input [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe.
   task rd_reg(input [7:0] a, output [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // Sampling point, then wait for the published result set.
   task sample;
      integer k;
      wr_reg(`TFM_REG_SAMPLE, 32'h0);
      ts = $time;
      for (k = 0; k < 300 && result_valid_o !== 1'b1; k = k + 1) begin
         @(posedge mclk_i);
         #1;
      end
      if (k == 300) give_up;
   endtask
   task wait_pin(input v);
      integer k;
      for (k = 0; k < 500 && sig_w[0] !== v; k = k + 1) @(posedge mclk_i);
      if (k == 500) give_up;
   endtask
   initial begin
      i = $urandom(26752);
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rd_reg(`TFM_REG_CTRL, rv); check(rv, 32'h0);
      rd_reg(`TFM_REG_CHSEL, rv); check(rv, 32'h100);
      rd_reg(`TFM_REG_PPC, rv); check(rv, 32'h1);
      rd_reg(8'h2C, rv); check(rv, 32'h0);
      rd_reg(`TFM_REG_SAMPLE, rv); check(rv, 32'h0);
      $display("test reset values done");
      // Steady waves; the first is the shortest legal shape.
      for (i = 0; i < 7; i = i + 1) begin
         h = (i == 0) ? 4 : 2 * (2 + $urandom % 60);
         l = (i == 0) ? 4 : 2 * (2 + $urandom % 60);
         p = 1 + $urandom % 4;
         win = $urandom % 2;
         fc = $urandom % 2;
         m = win ? p : 1;
         @(posedge mclk_i);
         hi_q <= h;
         lo_q <= l;
         wr_reg(`TFM_REG_CTRL, 32'h0);
         wr_reg(`TFM_REG_PPC, p);
         wr_reg(`TFM_REG_CTRL, fc * 1024 + ($urandom % 2) * 160 + win * 2 + 17);
         repeat ((2 * p + 2) * (h + l)) @(posedge mclk_i);
         sample;
         rd_reg(`TFM_REG_ACT, a0); check(a0, m * h / 2);
         rd_reg(`TFM_REG_INACT, rv); check(rv, m * l / 2);
         rd_reg(`TFM_REG_PERIOD, rv);
         check(rv, (fc ? p : 1) * (h + l) / 2);
         rd_reg(`TFM_REG_FREQ, rv); check(rv, freq_exp((fc ? p : 1) * (h + l) / 2, 0));
         rd_reg(`TFM_REG_DUTY, rv); check(rv, h * 100 / (h + l));
         rd_reg(`TFM_REG_RPM, rv); check(rv, `TFM_RPM_NUM / (p * (h + l) / 2));
      end
      $display("test steady waves done");
      // Sign modes, sampled mid high phase.
      @(posedge mclk_i);
      hi_q <= 16'h0028;
      lo_q <= 16'h0028;
      for (qm = 3; qm < 7; qm = qm + 1) begin
         for (q = 0; q < 2; q = q + 1) begin
            @(posedge mclk_i);
            qual_q <= q;
            wr_reg(`TFM_REG_CTRL, qm * 128 + 17);
            repeat (200) @(posedge mclk_i);
            wait_pin(1'b0);
            wait_pin(1'b1);
            repeat (18) @(posedge mclk_i);
            sample;
            neg = (qm == 3) ? !q : (qm == 4) ? q : (qm == 5) ? !q : q;
            rd_reg(`TFM_REG_FREQ, rv); check(rv, freq_exp(40, neg));
         end
      end
      $display("test sign modes done");
      // Gated accumulation, measured pin held active.
      @(posedge mclk_i);
      lo_q <= 16'h0000;
      qual_q <= 1'b0;
      wr_reg(`TFM_REG_CTRL, 32'h0);
      wr_reg(`TFM_REG_CTRL, 32'h87);
      repeat (20) @(posedge mclk_i);
      qual_q <= 1'b1;
      repeat (200) @(posedge mclk_i);
      qual_q <= 1'b0;
      repeat (20) @(posedge mclk_i);
      sample;
      rd_reg(`TFM_REG_ACT, a0); check(a0 >= 99 && a0 <= 101, 32'h1);
      @(posedge mclk_i);
      qual_q <= 1'b1;
      t0 = $time;
      repeat (20) @(posedge mclk_i);
      sample;
      rd_reg(`TFM_REG_ACT, rv); check(rv, a0);
      @(posedge mclk_i);
      qual_q <= 1'b0;
      m = a0 + ($time - t0) / 20;
      repeat (20) @(posedge mclk_i);
      sample;
      rd_reg(`TFM_REG_ACT, rv); check(rv - m + 1 <= 2, 32'h1);
      $display("test gated window done");
      // Free running accumulation across two sampling points.
      wr_reg(`TFM_REG_CTRL, 32'h0);
      wr_reg(`TFM_REG_CTRL, 32'h17);
      repeat (50) @(posedge mclk_i);
      sample;
      t0 = ts;
      rd_reg(`TFM_REG_ACT, a0);
      repeat (300) @(posedge mclk_i);
      sample;
      rd_reg(`TFM_REG_ACT, rv);
      m = rv - a0 - (ts - t0) / 20;
      check(m >= -1 && m <= 1, 32'h1);
      $display("test free running done");
      print_verdict;
   end
endmodule

// ==== verif/tfm_chk.sv ====
/*
 Port checker for one measurement channel, bound into every instance.
 Assumes ce_i stays high and strobes keep the one-cycle bus rules.
*/
`timescale 1ns/1ps
`include "tfm_defines.vh"
module tfm_chk #(
   parameter NCH  = 4,                  // Number of sensor pins.
   parameter IDXW = 2                   // Width of a channel index.
) (
   // Clock, reset and clock enable.
   input wire            mclk_i,
   input wire            rstn_i,
   input wire            ce_i,
   // Sensor pins.
   input wire [NCH-1:0]  sig_i,
   // Register port.
   input wire [7:0]      addr_i,
   input wire [31:0]     wdata_i,
   input wire            wr_i,
   input wire            rd_i,
   input wire [31:0]     rdata_o,
   // Result strobe.
   input wire            result_valid_o
);
   reg [10:0] ctrl_q;                   // Last control word written.
   reg [15:0] chsel_q;                  // Last pin selection written.
   reg [15:0] ppc_q;                    // Last periods per cycle written.
   reg [7:0]  since_q;                  // Cycles since a sampling point, saturating.
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   // Shadows track writes to predict read data.
   always @(posedge mclk_i) begin
      if (!rstn_i) begin
         ctrl_q  <= `TFM_CTRL_RST;
         chsel_q <= `TFM_CHSEL_RST;
         ppc_q   <= `TFM_PPC_RST;
         since_q <= 8'hFF;
      end else begin
         if (wr_i && addr_i == `TFM_REG_CTRL) ctrl_q <= wdata_i[10:0];
         if (wr_i && addr_i == `TFM_REG_CHSEL) chsel_q <= wdata_i[15:0];
         if (wr_i && addr_i == `TFM_REG_PPC) ppc_q <= wdata_i[15:0];
         if (wr_i && addr_i == `TFM_REG_SAMPLE) since_q <= 8'h00;
         else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
      end
   end
   a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside a read");
   a_ctrl_read_back: assert property ($past(rd_i && addr_i == `TFM_REG_CTRL)
      |-> rdata_o == {21'h0, $past(ctrl_q)}) else $error("control read back wrong");
   a_chsel_read_back: assert property ($past(rd_i && addr_i == `TFM_REG_CHSEL)
      |-> rdata_o == {16'h0, $past(chsel_q)}) else $error("selection read back wrong");
   a_ppc_read_back: assert property ($past(rd_i && addr_i == `TFM_REG_PPC)
      |-> rdata_o == {16'h0, $past(ppc_q)}) else $error("period count read back wrong");
   a_duty_in_range: assert property ($past(rd_i && addr_i == `TFM_REG_DUTY)
      |-> rdata_o <= 32'h64) else $error("duty above one hundred");
   a_freq_sat_sign: assert property ($past(rd_i && addr_i == `TFM_REG_FREQ)
      |-> rdata_o != 32'h8000_0000) else $error("frequency magnitude not saturated");
   a_valid_one_cycle: assert property (result_valid_o |=> !result_valid_o)
      else $error("result strobe longer than one cycle");
   a_valid_follows: assert property (wr_i && addr_i == `TFM_REG_SAMPLE && ctrl_q[0]
      |-> ##[1:200] result_valid_o) else $error("no result after sampling point");
   a_valid_has_cause: assert property (result_valid_o |-> since_q <= 8'hC8)
      else $error("result strobe without sampling point");
endmodule
bind tfm_channel tfm_chk #(.NCH(NCH), .IDXW(IDXW)) u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
   .ce_i(ce_i), .sig_i(sig_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .result_valid_o(result_valid_o));

// ==== verif/tfm_sensor.sv ====
/*
 Behavioural sensor: square wave on pin 0, a held qualifier on pin 1 and
 moving junk on pins 2 and 3. Assumes the bench sets the shape lengths.
*/
`timescale 1ns/1ps
module tfm_sensor (
   // Clock.
   input  wire        mclk_i,
   // Shape: clocks high and low; a zero low length keeps pin 0 high.
   input  wire [15:0] hi_len_i,
   input  wire [15:0] lo_len_i,
   input  wire        qual_i,
   // Sensor pins.
   output reg  [3:0]  sig_o
);
   reg [15:0] cnt_q = 16'h0000;         // Clocks spent in the current phase.
   initial sig_o = 4'h0;
   // Unused pins keep moving so a wrong pin selection shows.
   always @(posedge mclk_i) begin
      sig_o[1] <= qual_i;
      sig_o[3:2] <= sig_o[3:2] + 2'h1;
      if (lo_len_i == 16'h0000) begin
         sig_o[0] <= 1'b1;
         cnt_q <= 16'h0000;
      end else if (cnt_q + 16'h0001 >= (sig_o[0] ? hi_len_i : lo_len_i)) begin
         sig_o[0] <= !sig_o[0];
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule
